/* File: fws_cyc_if.sv */
/*
 Request and answer path between the controller and its cycle engine.
 Assumes a single mclk domain.
*/
`timescale 1ns/100ps
interface fws_cyc_if;
   logic req;
   logic wr;
   logic [fws_pkg::AW-1:0] addr;
   logic [fws_pkg::DW-1:0] wdata;
   logic done;
   logic [fws_pkg::DW-1:0] rdata;
   modport ctl (output req, wr, addr, wdata, input done, rdata);
   modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fws_cyc_if

/* File: fws_cycle.sv */
/*
 Flash asynchronous bus cycle engine: one read or write per request.
 Each read is a full chip-enable/output-enable cycle so toggle bits
 advance. Assumes the flash answers within the access time.
*/
`timescale 1ns/100ps
module fws_cycle (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Request side
   fws_cyc_if.eng cyc,
   // Flash pins
   output logic ceN,
   output logic oeN,
   output logic weN,
   output logic [fws_pkg::AW-1:0] flAddr,
   output logic [fws_pkg::DW-1:0] dqOut,
   output logic dqOe,
   input wire logic [fws_pkg::DW-1:0] dqSync
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ACT = 4'b0010,
      S_REC = 4'b0100,
      S_FIN = 4'b1000
   } fws_cst_t;
   fws_cst_t st_ff, nxt_st;
   logic [3:0] cnt_ff, nxt_cnt;
   logic wr_ff, nxt_wr;
   logic ceN_ff, nxt_ceN, oeN_ff, nxt_oeN, weN_ff, nxt_weN;
   logic dqOe_ff, nxt_dqOe, done_ff, nxt_done;
   logic [fws_pkg::AW-1:0] a_ff, nxt_a;
   logic [fws_pkg::DW-1:0] d_ff, nxt_d, r_ff, nxt_r;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_wr = wr_ff;
      nxt_ceN = ceN_ff;
      nxt_oeN = oeN_ff;
      nxt_weN = weN_ff;
      nxt_dqOe = dqOe_ff;
      nxt_done = 1'b0;
      nxt_a = a_ff;
      nxt_d = d_ff;
      nxt_r = r_ff;
      unique case (st_ff)
         S_IDLE: begin
            if (cyc.req) begin
               nxt_st = S_ACT;
               nxt_wr = cyc.wr;
               nxt_a = cyc.addr;
               nxt_d = cyc.wdata;
               nxt_ceN = 1'b0;
               nxt_oeN = cyc.wr;
               nxt_weN = !cyc.wr;
               nxt_dqOe = cyc.wr;
               // Sync adds two cycles to read latency
               nxt_cnt = cyc.wr ? fws_pkg::WP_CNT
                  : fws_pkg::ACC_CNT + fws_pkg::SYNC_CNT;
            end
         end
         S_ACT: begin
            if (cnt_ff != 4'h0) begin
               nxt_cnt = cnt_ff - 4'h1;
            end else begin
               // Raising all enables ends the read or write cycle; read data is captured here
               nxt_r = dqSync;
               nxt_ceN = 1'b1;
               nxt_oeN = 1'b1;
               nxt_weN = 1'b1;
               nxt_cnt = fws_pkg::REC_CNT;
               nxt_st = S_REC;
            end
         end
         S_REC: begin
            nxt_dqOe = 1'b0;
            if (cnt_ff != 4'h0) begin
               nxt_cnt = cnt_ff - 4'h1;
            end else begin
               nxt_done = 1'b1;
               nxt_st = S_FIN;
            end
         end
         S_FIN: begin
            nxt_st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         wr_ff <= 1'b0;
         ceN_ff <= 1'b1;
         oeN_ff <= 1'b1;
         weN_ff <= 1'b1;
         dqOe_ff <= 1'b0;
         done_ff <= 1'b0;
         a_ff <= '0;
         d_ff <= '0;
         r_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         ceN_ff <= nxt_ceN;
         oeN_ff <= nxt_oeN;
         weN_ff <= nxt_weN;
         dqOe_ff <= nxt_dqOe;
         done_ff <= nxt_done;
         a_ff <= nxt_a;
         d_ff <= nxt_d;
         r_ff <= nxt_r;
      end
   end

   assign cyc.done = done_ff;
   assign cyc.rdata = r_ff;
   assign ceN = ceN_ff;
   assign oeN = oeN_ff;
   assign weN = weN_ff;
   assign flAddr = a_ff;
   assign dqOut = d_ff;
   assign dqOe = dqOe_ff;
endmodule : fws_cycle

/* File: fws_flash_model.sv */
/*
 Behavioural NOR flash bank: status word while busy with addr[21] low, array data else.
 Assumes host pins settle before each enable edge.
*/
`timescale 1ns/100ps
module fws_flash_model #(
   parameter logic [15:0] ARR = 16'h5A3C
) (
   // Flash pins
   input wire logic oeN,
   input wire logic weN,
   input wire logic [21:0] addr,
   input wire logic [15:0] dq,
   output logic [15:0] dqDrv,
   output logic rbN,
   // Bench control
   input wire logic start,
   input wire logic [7:0] runLen,
   input wire logic hang,
   input wire logic timerOne,
   input wire logic susp,
   output logic [15:0] lastWr,
   output logic [21:0] rdAddr
);
   logic busy, togA, togB, limitHit, valid;
   logic [7:0] left;
   logic [15:0] word, last;
   // ==========================================================
   // Status word
   always_comb begin
      word = ARR ^ addr[15:0];
      if (busy && !addr[21]) begin
         word = 16'h0000;
         word[7] = susp;
         word[6] = togA;
         word[5] = limitHit;
         word[3] = timerOne;
         word[2] = togB;
      end
   end
   assign rbN = !busy || susp;
   // Released bus shows the inverse of its last value
   assign dqDrv = valid ? word : ~last;
   initial begin
      {busy, togA, togB, limitHit, valid} = 5'h00;
      left = 8'h00;
      last = 16'h0000;
      lastWr = 16'h0000;
      rdAddr = 22'h000000;
   end
   always @(posedge start) begin
      busy = 1'b1;
      left = runLen;
      limitHit = hang;
   end
   always @(negedge oeN) begin
      valid = 1'b0;
      #70 valid = !oeN;
   end
   // ==========================================================
   // Each completed read while busy advances togB, and togA too unless suspended
   always @(posedge oeN) begin
      last = word;
      valid = 1'b0;
      rdAddr = addr;
      if (busy) begin
         togB = !togB;
         // Suspend freezes the busy toggle and the erase progress
         if (!susp) begin
            togA = !togA;
            if (!limitHit && left == 8'h00) busy = 1'b0;
            else if (!limitHit) left = left - 8'h01;
         end
      end
   end
   always @(posedge weN) begin
      lastWr = dq;
      if (busy && limitHit && dq == 16'h00F0) begin
         busy = 1'b0;
         limitHit = 1'b0;
      end
   end
endmodule : fws_flash_model

/* File: fws_host.sv */
/*
 Host controller for NOR flash write-status polling, AXI4-Lite slave.
 Software writes ADDR/WDATA then CTRL; STATUS reports result.
 Assumes the flash bank under test is addressed by ADDR.
*/
`timescale 1ns/100ps
module fws_host (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Flash pins
   output logic flCeN,
   output logic flOeN,
   output logic flWeN,
   output logic [fws_pkg::AW-1:0] flAddr,
   output logic [fws_pkg::DW-1:0] dataBusOut,
   output logic dataBusOe,
   input wire logic [fws_pkg::DW-1:0] dataBusIn,
   input wire logic readyBusyN
);
   // ==========================================================
   // Pin synchronisers
   logic [fws_pkg::DW-1:0] dqS1_ff, dqS2_ff;
   logic rbS1_ff, rbS2_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dqS1_ff <= '0;
         dqS2_ff <= '0;
         rbS1_ff <= 1'b0;
         rbS2_ff <= 1'b0;
      end else begin
         dqS1_ff <= dataBusIn;
         dqS2_ff <= dqS1_ff;
         rbS1_ff <= readyBusyN;
         rbS2_ff <= rbS1_ff;
      end
   end

   fws_cyc_if cyc ();
   logic ceN, oeN, weN, dqOe;
   logic [fws_pkg::AW-1:0] pinA;
   logic [fws_pkg::DW-1:0] dqO;
   fws_cycle u_cycle (
      .mclk(mclk),
      .rst(rst),
      .cyc(cyc.eng),
      .ceN(ceN),
      .oeN(oeN),
      .weN(weN),
      .flAddr(pinA),
      .dqOut(dqO),
      .dqOe(dqOe),
      .dqSync(dqS2_ff)
   );

   // ==========================================================
   // Sequencer
   typedef enum logic [5:0] {
      P_IDLE = 6'b000001,
      P_CYC = 6'b000010,
      P_FIRST = 6'b000100,
      P_SECOND = 6'b001000,
      P_LIMIT = 6'b010000,
      P_RECHK = 6'b100000
   } fws_pst_t;
   fws_pst_t st_ff, nxt_st;
   logic [2:0] cmd_ff, nxt_cmd;
   logic [fws_pkg::AW-1:0] addr_ff, nxt_addr;
   logic [fws_pkg::DW-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd, prev_ff, nxt_prev;
   logic busy_ff, nxt_busy, done_ff, nxt_done, fail_ff, nxt_fail;
   logic tmr_ff, nxt_tmr, sect_ff, nxt_sect;
   logic req_ff, nxt_req;
   logic start;
   logic [2:0] startCmd;
   logic [fws_pkg::DW-1:0] diff;

   assign diff = cyc.rdata ^ prev_ff;

   always_comb begin
      nxt_st = st_ff;
      nxt_cmd = cmd_ff;
      nxt_wd = wd_ff;
      nxt_rd = rd_ff;
      nxt_prev = prev_ff;
      nxt_busy = busy_ff;
      nxt_done = done_ff;
      nxt_fail = fail_ff;
      nxt_tmr = tmr_ff;
      nxt_sect = sect_ff;
      nxt_req = 1'b0;
      unique case (st_ff)
         P_IDLE: begin
            if (start && startCmd != fws_pkg::CMD_NONE) begin
               nxt_cmd = startCmd;
               nxt_busy = 1'b1;
               nxt_done = 1'b0;
               nxt_fail = 1'b0;
               nxt_req = 1'b1;
               // Poll always begins from the first read
               nxt_st = (startCmd == fws_pkg::CMD_POLL) ? P_FIRST : P_CYC;
            end
         end
         P_CYC: begin
            if (cyc.done) begin
               nxt_rd = cyc.rdata;
               if (cmd_ff == fws_pkg::CMD_TIMER) begin
                  // Latch the timer bit from this single status read
                  nxt_tmr = cyc.rdata[fws_pkg::BIT_TIMER];
               end
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_st = P_IDLE;
            end
         end
         P_FIRST: begin
            if (cyc.done) begin
               nxt_prev = cyc.rdata;
               nxt_req = 1'b1;
               nxt_st = P_SECOND;
            end
         end
         P_SECOND: begin
            if (cyc.done) begin
               nxt_rd = cyc.rdata;
               nxt_sect = diff[fws_pkg::BIT_SECT];
               if (!diff[fws_pkg::BIT_BUSY]) begin
                  // Stopped toggling: complete
                  nxt_busy = 1'b0;
                  nxt_done = 1'b1;
                  nxt_st = P_IDLE;
               end else if (cyc.rdata[fws_pkg::BIT_LIMIT]) begin
                  // Limit high: recheck toggling
                  nxt_prev = cyc.rdata;
                  nxt_req = 1'b1;
                  nxt_st = P_LIMIT;
               end else begin
                  nxt_prev = cyc.rdata;
                  nxt_req = 1'b1;
               end
            end
         end
         P_LIMIT: begin
            if (cyc.done) begin
               nxt_rd = cyc.rdata;
               if (diff[fws_pkg::BIT_BUSY]) begin
                  // Failure: write reset command
                  nxt_fail = 1'b1;
                  nxt_cmd = fws_pkg::CMD_WRITE;
                  nxt_wd = fws_pkg::RESET_DATA;
                  nxt_req = 1'b1;
                  nxt_st = P_RECHK;
               end else begin
                  nxt_busy = 1'b0;
                  nxt_done = 1'b1;
                  nxt_st = P_IDLE;
               end
            end
         end
         P_RECHK: begin
            if (cyc.done) begin
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
               nxt_st = P_IDLE;
            end
         end
         default: nxt_st = P_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_ff <= P_IDLE;
         cmd_ff <= fws_pkg::CMD_NONE;
         rd_ff <= '0;
         prev_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
         tmr_ff <= 1'b0;
         sect_ff <= 1'b0;
         req_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cmd_ff <= nxt_cmd;
         rd_ff <= nxt_rd;
         prev_ff <= nxt_prev;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         fail_ff <= nxt_fail;
         tmr_ff <= nxt_tmr;
         sect_ff <= nxt_sect;
         req_ff <= nxt_req;
      end
   end

   // Status reads target the software address
   assign cyc.req = req_ff;
   assign cyc.wr = (cmd_ff == fws_pkg::CMD_WRITE);
   assign cyc.addr = addr_ff;
   assign cyc.wdata = wd_ff;

   // ==========================================================
   // AXI4-Lite slave
   logic awOk_ff, nxt_awOk, wOk_ff, nxt_wOk, bv_ff, nxt_bv;
   logic [7:0] awA_ff, nxt_awA;
   logic [31:0] wD_ff, nxt_wD;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rv_ff, nxt_rv;
   logic [31:0] rdat_ff, nxt_rdat;
   logic [1:0] rresp_ff, nxt_rresp;
   logic doWr;

   assign doWr = awOk_ff && wOk_ff && !bv_ff;
   assign start = doWr && awA_ff == fws_pkg::REG_CTRL && wD_ff[0 +: 3] != 3'h0;
   assign startCmd = wD_ff[2:0];

   always_comb begin
      nxt_awOk = awOk_ff;
      nxt_wOk = wOk_ff;
      nxt_awA = awA_ff;
      nxt_wD = wD_ff;
      nxt_bv = bv_ff;
      nxt_bresp = bresp_ff;
      nxt_addr = addr_ff;
      nxt_rv = rv_ff;
      nxt_rdat = rdat_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_awvalid && !awOk_ff) begin
         nxt_awOk = 1'b1;
         nxt_awA = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wOk_ff) begin
         nxt_wOk = 1'b1;
         nxt_wD = s_axi_wdata;
      end
      if (doWr) begin
         nxt_awOk = 1'b0;
         nxt_wOk = 1'b0;
         nxt_bv = 1'b1;
         nxt_bresp = 2'h0;
         unique case (awA_ff)
            fws_pkg::REG_ADDR: nxt_addr = wD_ff[fws_pkg::AW-1:0];
            fws_pkg::REG_CTRL: nxt_bresp = busy_ff ? 2'h2 : 2'h0;
            fws_pkg::REG_WDATA, fws_pkg::REG_STATUS, fws_pkg::REG_RDATA: ;
            default: nxt_bresp = 2'h2;
         endcase
      end
      if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
      if (s_axi_arvalid && !rv_ff) begin
         nxt_rv = 1'b1;
         nxt_rresp = 2'h0;
         unique case (s_axi_araddr)
            fws_pkg::REG_CTRL: nxt_rdat = {29'h0, cmd_ff};
            fws_pkg::REG_ADDR: nxt_rdat = {10'h0, addr_ff};
            fws_pkg::REG_WDATA: nxt_rdat = {16'h0, wd_ff};
            fws_pkg::REG_STATUS: nxt_rdat = {26'h0, sect_ff, rbS2_ff,
               tmr_ff, fail_ff, done_ff, busy_ff};
            fws_pkg::REG_RDATA: nxt_rdat = {16'h0, rd_ff};
            default: begin
               nxt_rdat = 32'h0;
               nxt_rresp = 2'h2;
            end
         endcase
      end else if (rv_ff && s_axi_rready) begin
         nxt_rv = 1'b0;
      end
   end

   // WDATA writes go through the write path below
   logic [fws_pkg::DW-1:0] wdReg;
   assign wdReg = (doWr && awA_ff == fws_pkg::REG_WDATA) ?
      wD_ff[fws_pkg::DW-1:0] : nxt_wd;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awOk_ff <= 1'b0;
         wOk_ff <= 1'b0;
         awA_ff <= 8'h00;
         wD_ff <= 32'h0;
         bv_ff <= 1'b0;
         bresp_ff <= 2'h0;
         addr_ff <= '0;
         wd_ff <= '0;
         rv_ff <= 1'b0;
         rdat_ff <= 32'h0;
         rresp_ff <= 2'h0;
      end else begin
         awOk_ff <= nxt_awOk;
         wOk_ff <= nxt_wOk;
         awA_ff <= nxt_awA;
         wD_ff <= nxt_wD;
         bv_ff <= nxt_bv;
         bresp_ff <= nxt_bresp;
         addr_ff <= nxt_addr;
         wd_ff <= wdReg;
         rv_ff <= nxt_rv;
         rdat_ff <= nxt_rdat;
         rresp_ff <= nxt_rresp;
      end
   end

   assign s_axi_awready = !awOk_ff;
   assign s_axi_wready = !wOk_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rv_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata = rdat_ff;
   assign s_axi_rresp = rresp_ff;
   assign flCeN = ceN;
   assign flOeN = oeN;
   assign flWeN = weN;
   assign flAddr = pinA;
   assign dataBusOut = dqO;
   assign dataBusOe = dqOe;
endmodule : fws_host

/* File: fws_host_bench.sv */
/*
 Self-checking bench: AXI4-Lite master, flash model, random polls.
 Assumes the checker is bound to fws_host.
*/
`timescale 1ns/100ps
module fws_host_bench;
   localparam logic [15:0] ARR = 16'h5A3C;
   localparam logic [31:0] MSK = 32'h17;
   logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, h;
   logic awready, wready, bvalid, arready, rvalid, ceN, oeN, weN, dqOe;
   logic rbN, start, hang, timerOne, susp;
   logic [7:0] awaddr, araddr, runLen;
   logic [31:0] wdata, rdata, rd, st;
   logic [1:0] bresp, rresp, rsp;
   logic [21:0] flAddr, a, rdAddr;
   logic [15:0] dqOut, dqDrv, dqWire, lastWr, d;
   int miscompares, n_checks, i;
   assign dqWire = dqOe ? dqOut : dqDrv;
   fws_host u_fws_host (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flCeN(ceN),
      .flOeN(oeN), .flWeN(weN), .flAddr(flAddr), .dataBusOut(dqOut),
      .dataBusOe(dqOe), .dataBusIn(dqWire), .readyBusyN(rbN));
   fws_flash_model #(.ARR(ARR)) u_fws_flash_model (.oeN(oeN), .weN(weN),
      .addr(flAddr), .dq(dqWire), .dqDrv(dqDrv), .rbN(rbN), .start(start),
      .runLen(runLen), .hang(hang), .timerOne(timerOne), .susp(susp),
      .lastWr(lastWr), .rdAddr(rdAddr));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = !mclk;
   end
   // ==========================================================
   // Checks and expectations
   task automatic tally_and_finish();
      if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stall();
      miscompares++;
      $display("[FAIL] %0t wait timed out", $time);
      tally_and_finish();
   endtask : stall
   function automatic logic [31:0] expPoll(input logic lim);
      expPoll = 32'h12;
      expPoll[fws_pkg::ST_FAIL] = lim;
   endfunction : expPoll
   // ==========================================================
   // AXI4-Lite master
   task automatic axiWr(input logic [7:0] ad, input logic [31:0] v);
      int n;
      @(posedge mclk);
      awaddr <= ad;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 100) stall();
      rsp = bresp;
      bready <= 1'b0;
   endtask : axiWr
   task automatic axiRd(input logic [7:0] ad);
      int n;
      @(posedge mclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 100) stall();
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : axiRd
   task automatic waitIdle();
      int n;
      for (n = 0; n < 400; n++) begin
         axiRd(fws_pkg::REG_STATUS);
         if (rd[fws_pkg::ST_BUSY] === 1'b0) break;
      end
      if (n == 400) stall();
      st = rd;
   endtask : waitIdle
   task automatic run(input logic [2:0] c, input logic [21:0] ad);
      axiWr(fws_pkg::REG_ADDR, 32'(ad));
      axiWr(fws_pkg::REG_CTRL, 32'(c));
      waitIdle();
   endtask : run
   // ==========================================================
   // Main sequence
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {start, hang, timerOne, susp} = 4'h0;
      {awaddr, araddr, runLen, wdata} = 56'h0;
      miscompares = 0;
      n_checks = 0;
      void'($urandom(32'h54951a65));
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      axiRd(fws_pkg::REG_STATUS);
      check(rd & 32'h1F, 32'h10);
      axiRd(8'h14);
      check(rd, 32'h0);
      check(32'(rsp), 32'h2);
      axiWr(8'h20, 32'h1);
      check(32'(rsp), 32'h2);
      for (i = 0; i < 12; i++) begin
         h = (i % 4 == 3);
         d = 16'($urandom);
         a = {1'b0, 21'($urandom)};
         runLen <= 8'($urandom_range(2, 20));
         timerOne <= 1'($urandom);
         axiWr(fws_pkg::REG_WDATA, 32'(d));
         run(fws_pkg::CMD_WRITE, 22'($urandom));
         check(32'(lastWr), 32'(d));
         if (i > 0) begin
            hang <= h;
            start <= 1'b1;
            @(posedge mclk);
            start <= 1'b0;
         end
         // Other bank keeps giving array data while this one works
         run(fws_pkg::CMD_READ, {1'b1, a[20:0]});
         axiRd(fws_pkg::REG_RDATA);
         check(rd & 32'hFFFF, 32'(ARR ^ a[15:0]));
         if (i > 0) begin
            run(fws_pkg::CMD_TIMER, a);
            check(32'(st[fws_pkg::ST_TIMER]), 32'(timerOne));
         end
         // One poll sees a suspended erase
         susp <= (i == 1);
         axiWr(fws_pkg::REG_ADDR, 32'(a));
         axiWr(fws_pkg::REG_CTRL, 32'(fws_pkg::CMD_POLL));
         axiWr(fws_pkg::REG_CTRL, 32'(fws_pkg::CMD_POLL));
         check(32'(rsp), 32'h2);
         waitIdle();
         check(st & MSK, expPoll(h && i > 0));
         check(32'(rdAddr), 32'(a));
         if (h && i > 0) check(32'(lastWr), 32'h00F0);
         if (i == 1 || (h && i > 0))
            check(32'(st[fws_pkg::ST_SECT]), 32'h1);
         susp <= 1'b0;
         run(fws_pkg::CMD_POLL, a);
         check(st & MSK, expPoll(1'b0));
      end
      tally_and_finish();
   end
endmodule : fws_host_bench

/* File: fws_host_checker.sv */
/*
 Concurrent checks on the host controller's ports.
 Assumes one mclk domain and an asynchronous active-high rst.
*/
`timescale 1ns/100ps
module fws_host_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // AXI4-Lite
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Flash pins
   input wire logic flCeN,
   input wire logic flOeN,
   input wire logic flWeN,
   input wire logic dataBusOe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence sWrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence sWePulse;
      !flWeN [*3] ##1 flWeN;
   endsequence
   // ==========================================================
   // Bus answers
   a_write_answer: assert property (sWrTaken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   // ==========================================================
   // Flash cycles; recovery keeps each read distinct
   a_we_pulse: assert property ($fell(flWeN) |-> sWePulse)
      else $error("write pulse length");
   a_we_drive: assert property (!flWeN |-> !flCeN && flOeN && dataBusOe)
      else $error("write cycle pins");
   a_oe_quiet: assert property (!flOeN |-> !flCeN && flWeN && !dataBusOe)
      else $error("read cycle pins");
   a_read_len: assert property ($fell(flOeN) |-> !flOeN [*8] ##1 flOeN)
      else $error("read cycle length");
   a_ce_recover: assert property ($rose(flCeN) |-> flCeN [*3])
      else $error("recovery too short");
endmodule : fws_host_checker
bind fws_host fws_host_checker u_fws_host_checker (.mclk(mclk), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .flCeN(flCeN), .flOeN(flOeN), .flWeN(flWeN), .dataBusOe(dataBusOe));

/* File: fws_pkg.sv */
/*
 Constants for the flash write-status host controller: register map,
 command codes, status bit positions and flash pin timing.
 Assumes a 50 MHz mclk and a 16-bit asynchronous NOR flash bus.
*/
// What this block does
// - Two back-to-back reads; no change means done
// - Toggling: check limit flag, recheck, else failure
// - Resumed monitoring restarts the whole procedure; the code stays in P_SECOND and compares each new read with the last
// - After limit failure host issues reset command
// - Under 50 us spacing host may skip timer
// - Confirm acceptance, check timer before and after
// - Status reads use a valid sector address
// - Status reads address the busy bank
package fws_pkg;
   // ==========================================================
   // Register map (byte offsets)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   // CTRL command codes in bits 2:0, write of nonzero starts when idle
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_READ = 3'h2;
   localparam logic [2:0] CMD_POLL = 3'h3;
   localparam logic [2:0] CMD_TIMER = 3'h4;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_TIMER = 3;
   localparam int ST_RDY = 4;
   localparam int ST_SECT = 5;
   // Flash data bus bit positions
   localparam int BIT_SECT = 2;
   localparam int BIT_TIMER = 3;
   localparam int BIT_LIMIT = 5;
   localparam int BIT_BUSY = 6;
   // Widths
   localparam int AW = 22;
   localparam int DW = 16;
   // ==========================================================
   // Timing
   localparam int CLK_NS = 20;
   localparam int T_ACC_NS = 90;
   localparam int T_WP_NS = 35;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] ACC_CNT = 4'(ACC_CYC);
   localparam logic [3:0] WP_CNT = 4'(WP_CYC);
   localparam logic [3:0] REC_CNT = 4'h2;
   localparam logic [3:0] SYNC_CNT = 4'h2;
   // Data word of the reset command
   localparam logic [15:0] RESET_DATA = 16'h00F0;
   // Bus op kinds
   typedef enum logic [1:0] {
      OP_RD = 2'h0,
      OP_WR = 2'h1
   } fws_op_t;
endpackage : fws_pkg
